// ### hdl/sac_defs.svh
// constants shared by the access command core and its controller
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
// ==========================================================
// widths
`define SAC_DQW      32
`define SAC_ADW      12
`define SAC_COLW     9
`define SAC_NBYTE    4
`define SAC_NBANK    4
`define SAC_RAMW     11
`define SAC_AP_BIT   10
// ==========================================================
// command codes as {ras_n, cas_n, we_n}
`define SAC_CMD_MRS  3'h0
`define SAC_CMD_REF  3'h1
`define SAC_CMD_PRE  3'h2
`define SAC_CMD_ACT  3'h3
`define SAC_CMD_WR   3'h4
`define SAC_CMD_RD   3'h5
`define SAC_CMD_STOP 3'h6
`define SAC_CMD_NOP  3'h7
// ==========================================================
// burst length codes: 0..3 give 1,2,4,8 beats
`define SAC_BL_PAGE  3'h7
`define SAC_PAGE_LEN 10'h200
`define SAC_CL3      2'h3
`define SAC_WAP_DLY  2'h2
`define SAC_MASK_CYC 2'h2
// ==========================================================
// controller register word addresses
`define SAC_REG_CFG  3'h0
`define SAC_REG_CMD  3'h1
`define SAC_REG_WDAT 3'h2
`define SAC_REG_RDAT 3'h3
`define SAC_REG_STAT 3'h4
// config fields
`define SAC_CFG_W    11
`define SAC_CFG_BL   2:0
`define SAC_CFG_IL   3
`define SAC_CFG_CL   5:4
`define SAC_CFG_CKE  6
`define SAC_CFG_DQM  10:7
`define SAC_CFG_RST  11'h060
// command fields
`define SAC_CMD_W    18
`define SAC_CMD_CODE 2:0
`define SAC_CMD_SELF 3
`define SAC_CMD_BANK 5:4
`define SAC_CMD_ADDR 17:6
`define SAC_CMD_AP   16
// status fields
`define SAC_ST_BUSY  0
`define SAC_ST_ESTOP 1
`define SAC_ST_EAP   2
`define SAC_ST_RVAL  3
`define SAC_ST_CKE   4
`endif

// ### hdl/sac_pkg.sv
// types and shared helpers of the access command core
`include "sac_defs.svh"
package sac_pkg;
   // ==========================================================
   // controller sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_MASK  = 3'h2,
      ST_DRIVE = 3'h4
   } sac_state_e;

   // ==========================================================
   // beats in one burst for a length code
   function automatic logic [9:0] sac_beats(input logic [2:0] code);
      logic [9:0] n;
      n = 10'h1 << code;
      if (code == `SAC_BL_PAGE) begin
         n = `SAC_PAGE_LEN;
      end
      return n;
   endfunction : sac_beats
endpackage : sac_pkg

// ### hdl/sac_if.sv
// command bus between the memory controller and the memory device
`include "sac_defs.svh"
interface sac_if;
   // command, address and mask lines
   logic                  cs_n;
   logic                  ras_n;
   logic                  cas_n;
   logic                  we_n;
   logic                  cke;
   logic [1:0]            ba;
   logic [`SAC_ADW-1:0]   addr;
   logic [`SAC_NBYTE-1:0] dqm;
   // mode lines standing in for the programmed mode register
   logic [2:0]            burst_len;
   logic                  interleave;
   logic [1:0]            cas_lat;
   // data pins split into driver halves
   logic [`SAC_DQW-1:0]   ctl_dq;
   logic                  ctl_dq_oe;
   logic [`SAC_DQW-1:0]   dev_dq;
   logic [`SAC_NBYTE-1:0] dev_dq_oe;
   wire  [`SAC_DQW-1:0]   dq;

   // undriven lanes read as zero; device zeroes its masked lanes
   assign dq = ctl_dq_oe ? ctl_dq : dev_dq;

   modport ctl (
      output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm,
      output burst_len, interleave, cas_lat, ctl_dq, ctl_dq_oe,
      input  dq, dev_dq_oe
   );
   modport dev (
      input  cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm,
      input  burst_len, interleave, cas_lat, dq,
      output dev_dq, dev_dq_oe
   );
endinterface : sac_if

// ### hdl/sac_device.sv
// memory end: command decode, bursts, precharge, refresh, power down
//
// Contract
// - strobes select access; we_n picks read/write
// - new row needs precharge then activate
// - accept read/write on every clock
// - burst type, length from mode; column starts
// - write data from command edge on
// - read restarts burst; old data drains
// - controller masks read data under write
// - write restarts write burst, full length
// - read ends write burst at once
// - controller frees pins before read data
// - burst stop only with full page
// - burst stop decode; read drains over latency
// - sequential order wraps in aligned block
// - interleaved order inverts low column bits
// - auto close bit; read closes early
// - no access to auto-closing bank
// - write auto close two clocks after
// - precharge decode; bank or all
// - self refresh while clock gate low
// - refresh bursts around self refresh
// - power down gates receivers
// - nop after power down exit
// - nop decode; burst continues
`include "sac_defs.svh"
module sac_device (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   // memory bus
   sac_if.dev                          mem,
   // status
   output logic [`SAC_NBANK-1:0]       o_bank_open,
   output logic                        o_read_burst,
   output logic                        o_write_burst,
   output logic                        o_self_refresh,
   output logic                        o_power_down
);
   // ==========================================================
   // helpers
   function automatic logic [3:0] bank_1h(input logic [1:0] b);
      return 4'h1 << b;
   endfunction : bank_1h

   function automatic logic [8:0] col_at(
      input logic [8:0] base,
      input logic [9:0] idx,
      input logic [2:0] code,
      input logic       il
   );
      logic [9:0] m;
      logic [8:0] msk;
      logic [8:0] seq;
      m   = sac_pkg::sac_beats(code) - 10'h1;
      msk = m[8:0];
      seq = (base & ~msk) | ((base + idx[8:0]) & msk);
      if (il && code != `SAC_BL_PAGE) begin
         seq = base ^ (idx[8:0] & msk);
      end
      return seq;
   endfunction : col_at

   // ==========================================================
   // state
   logic [`SAC_DQW-1:0]   ram [0:(1<<`SAC_RAMW)-1];
   logic                  cke_r;
   logic                  sr_r;
   logic                  pd_r;
   logic [`SAC_NBANK-1:0] open_r;
   logic                  rd_r;
   logic                  wr_r;
   logic [1:0]            bk_r;
   logic [8:0]            base_r;
   logic [9:0]            idx_r;
   logic                  ap_r;
   logic [1:0]            wap_cnt_r;
   logic [1:0]            wap_bk_r;
   logic [`SAC_DQW-1:0]   p0_r;
   logic                  p0_v_r;
   logic [`SAC_DQW-1:0]   p1_r;
   logic                  p1_v_r;
   logic [`SAC_NBYTE-1:0] m0_r;
   logic [`SAC_DQW-1:0]   dq_r;
   logic [`SAC_NBYTE-1:0] oe_r;

   // ==========================================================
   // command decode
   wire [2:0] code = {mem.ras_n, mem.cas_n, mem.we_n};
   // receivers are dead in power down and self refresh
   wire cmd_ok  = cke_r & ~pd_r & ~sr_r & ~mem.cs_n;
   wire busy    = rd_r | wr_r;
   wire is_rd   = cmd_ok & (code == `SAC_CMD_RD);
   wire is_wr   = cmd_ok & (code == `SAC_CMD_WR);
   wire is_act  = cmd_ok & (code == `SAC_CMD_ACT);
   wire is_pre  = cmd_ok & (code == `SAC_CMD_PRE);
   wire is_stop = cmd_ok & (code == `SAC_CMD_STOP);
   wire is_sr   = cmd_ok & (code == `SAC_CMD_REF)
                  & ~mem.cke & ~|open_r & ~busy;
   wire ap_bit  = mem.addr[`SAC_AP_BIT];
   // nop and deselect fall through every decode above
   wire pre_hit = is_pre & (ap_bit | (mem.ba == bk_r));
   wire cut     = is_rd | is_wr | is_stop | pre_hit;
   wire start   = is_rd | is_wr;
   // a low gate during a burst freezes it
   wire adv     = cke_r;

   // ==========================================================
   // burst addressing
   wire [9:0] len   = sac_pkg::sac_beats(mem.burst_len);
   wire       page  = (mem.burst_len == `SAC_BL_PAGE);
   wire [8:0] col_w = col_at(base_r, idx_r, mem.burst_len,
                             mem.interleave);
   wire [1:0] a_bk  = start ? mem.ba : bk_r;
   wire [8:0] a_col = start ? mem.addr[`SAC_COLW-1:0] : col_w;
   wire [`SAC_RAMW-1:0] a_ram = {a_bk, a_col};
   wire rd_beat = is_rd | (rd_r & adv & ~cut);
   wire wr_beat = is_wr | (wr_r & adv & ~cut);
   wire [9:0] cur   = start ? 10'h0 : idx_r;
   wire       last  = (cur == len - 10'h1) & ~page;
   wire       ap_c  = start ? ap_bit : ap_r;
   wire rd_nxt  = rd_beat ? ~last : (rd_r & ~adv);
   wire wr_nxt  = wr_beat ? ~last : (wr_r & ~adv);

   // ==========================================================
   // bank closing
   wire [9:0] left  = len - cur;
   wire rap_cls = rd_beat & ap_c
                  & (left <= {8'h0, mem.cas_lat});
   wire wap_cls = (wap_cnt_r == 2'h1);
   wire [3:0] act_m = is_act ? bank_1h(mem.ba) : 4'h0;
   wire [3:0] pre_m = is_pre ? (ap_bit ? 4'hF : bank_1h(mem.ba))
                             : 4'h0;
   wire [3:0] rap_m = rap_cls ? bank_1h(a_bk) : 4'h0;
   wire [3:0] wap_m = wap_cls ? bank_1h(wap_bk_r) : 4'h0;
   wire [3:0] cls_m = pre_m | rap_m | wap_m;

   // ==========================================================
   // read output stage
   wire cl3 = (mem.cas_lat == `SAC_CL3);
   wire [`SAC_DQW-1:0] pd_w = cl3 ? p1_r : p0_r;
   wire                pv_w = cl3 ? p1_v_r : p0_v_r;
   // mask sampled two edges before the data edge
   wire [`SAC_NBYTE-1:0] oe_nxt = {`SAC_NBYTE{pv_w}} & ~m0_r;
   wire [`SAC_DQW-1:0]   lane_m = {{8{oe_nxt[3]}}, {8{oe_nxt[2]}},
                                   {8{oe_nxt[1]}}, {8{oe_nxt[0]}}};

   // ==========================================================
   // power state and banks
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cke_r  <= 1'b0;
         sr_r   <= 1'b0;
         pd_r   <= 1'b0;
         open_r <= '0;
      end else begin
         cke_r  <= mem.cke;
         sr_r   <= sr_r ? ~mem.cke : is_sr;
         pd_r   <= ~mem.cke & ~busy & ~sr_r & ~is_sr;
         open_r <= (open_r & ~cls_m) | act_m;
      end
   end

   // ==========================================================
   // burst sequencing
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rd_r      <= 1'b0;
         wr_r      <= 1'b0;
         bk_r      <= '0;
         base_r    <= '0;
         idx_r     <= '0;
         ap_r      <= 1'b0;
         wap_cnt_r <= '0;
         wap_bk_r  <= '0;
      end else begin
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         if (start) begin
            bk_r   <= mem.ba;
            base_r <= mem.addr[`SAC_COLW-1:0];
            ap_r   <= ap_bit;
         end
         if (rd_beat | wr_beat) begin
            idx_r <= cur + 10'h1;
         end
         if (wr_beat & last & ap_c) begin
            wap_cnt_r <= `SAC_WAP_DLY;
            wap_bk_r  <= a_bk;
         end else if (wap_cnt_r != 2'h0) begin
            wap_cnt_r <= wap_cnt_r - 2'h1;
         end
      end
   end

   // ==========================================================
   // storage; masked lanes keep their old contents
   always_ff @(posedge i_clk) begin
      p0_r <= ram[a_ram];
      for (int b = 0; b < `SAC_NBYTE; b++) begin
         if (wr_beat & ~mem.dqm[b]) begin
            ram[a_ram][b*8 +: 8] <= mem.dq[b*8 +: 8];
         end
      end
   end

   // ==========================================================
   // read pipe; stopped bursts drain over the latency
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         p0_v_r <= 1'b0;
         p1_r   <= '0;
         p1_v_r <= 1'b0;
         m0_r   <= '0;
         dq_r   <= '0;
         oe_r   <= '0;
      end else begin
         p0_v_r <= rd_beat;
         p1_r   <= p0_r;
         p1_v_r <= p0_v_r;
         m0_r   <= mem.dqm;
         dq_r   <= pd_w & lane_m;
         oe_r   <= oe_nxt;
      end
   end

   assign mem.dev_dq      = dq_r;
   assign mem.dev_dq_oe   = oe_r;
   assign o_bank_open     = open_r;
   assign o_read_burst    = rd_r;
   assign o_write_burst   = wr_r;
   assign o_self_refresh  = sr_r;
   assign o_power_down    = pd_r;
endmodule : sac_device

// ### hdl/sac_ctrl.sv
// controller end: register file on the system bus, command sequencer
`include "sac_defs.svh"
module sac_ctrl (
   // clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   // register bus
   input  wire logic [2:0]           i_avs_address,
   input  wire logic                 i_avs_read,
   input  wire logic                 i_avs_write,
   input  wire logic [31:0]          i_avs_writedata,
   output logic      [31:0]          o_avs_readdata,
   output logic                      o_avs_waitrequest,
   // memory bus
   sac_if.ctl                        mem
);
   // ==========================================================
   // state
   sac_pkg::sac_state_e      state_r;
   logic [1:0]               mcnt_r;
   logic [`SAC_CFG_W-1:0]    cfg_r;
   logic [`SAC_CMD_W-1:0]    cmd_r;
   logic [31:0]              wdat_r;
   logic [31:0]              rdat_r;
   logic                     estop_r;
   logic                     eap_r;
   logic                     rval_r;
   logic                     wait_r;
   logic [31:0]              rd_r;
   logic [9:0]               wleft_r;
   logic [9:0]               rleft_r;
   logic [3:0]               bus_r;
   logic [1:0]               ba_r;
   logic [`SAC_ADW-1:0]      addr_r;
   logic [`SAC_NBYTE-1:0]    dqm_r;
   logic [`SAC_DQW-1:0]      dq_r;
   logic                     oe_r;

   // ==========================================================
   // bus decode
   wire is_cmd  = (i_avs_address == `SAC_REG_CMD);
   wire idle    = (state_r == sac_pkg::ST_IDLE);
   wire in_mask = (state_r == sac_pkg::ST_MASK);
   // orders wait while the last one is still on the bus
   wire take    = wait_r & (i_avs_read | i_avs_write)
                  & ~(i_avs_write & is_cmd & ~idle);
   wire wr_take = take & i_avs_write;
   wire rd_take = take & i_avs_read;
   wire [2:0] nc = i_avs_writedata[`SAC_CMD_CODE];
   wire page    = (cfg_r[`SAC_CFG_BL] == `SAC_BL_PAGE);
   wire [9:0] blen = sac_pkg::sac_beats(cfg_r[`SAC_CFG_BL]);
   wire bad_stop = (nc == `SAC_CMD_STOP) & ~page;
   wire bad_ap  = ((nc == `SAC_CMD_RD) | (nc == `SAC_CMD_WR))
                  & i_avs_writedata[`SAC_CMD_AP] & page;
   wire new_cmd = wr_take & is_cmd & ~bad_stop & ~bad_ap;
   wire need_mk = (nc == `SAC_CMD_WR) & (rleft_r != 10'h0);
   wire fire    = (new_cmd & ~need_mk) | (in_mask & (mcnt_r == 2'h1));
   wire [`SAC_CMD_W-1:0] src = in_mask ? cmd_r
                                       : i_avs_writedata[`SAC_CMD_W-1:0];
   wire [2:0] sc   = src[`SAC_CMD_CODE];
   wire f_wr   = fire & (sc == `SAC_CMD_WR);
   wire f_rd   = fire & (sc == `SAC_CMD_RD);
   wire f_sr   = fire & (sc == `SAC_CMD_REF) & src[`SAC_CMD_SELF];
   wire cap    = |mem.dev_dq_oe;
   wire [31:0] stat = {27'h0, cfg_r[`SAC_CFG_CKE], rval_r, eap_r,
                       estop_r, ~idle | (wleft_r != 10'h0)};
   wire [31:0] rd_mux =
      (i_avs_address == `SAC_REG_CFG)  ? {21'h0, cfg_r} :
      (i_avs_address == `SAC_REG_CMD)  ? {14'h0, cmd_r} :
      (i_avs_address == `SAC_REG_WDAT) ? wdat_r :
      (i_avs_address == `SAC_REG_RDAT) ? rdat_r :
      (i_avs_address == `SAC_REG_STAT) ? stat : 32'h0;
   wire st_w   = wr_take & (i_avs_address == `SAC_REG_STAT);

   // ==========================================================
   // registers and bus answer
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg_r   <= `SAC_CFG_RST;
         cmd_r   <= '0;
         wdat_r  <= '0;
         rdat_r  <= '0;
         estop_r <= 1'b0;
         eap_r   <= 1'b0;
         rval_r  <= 1'b0;
         wait_r  <= 1'b1;
         rd_r    <= '0;
      end else begin
         wait_r <= ~take;
         if (rd_take) begin
            rd_r <= rd_mux;
         end
         if (wr_take & (i_avs_address == `SAC_REG_CFG)) begin
            cfg_r <= i_avs_writedata[`SAC_CFG_W-1:0];
         end else if (f_sr) begin
            cfg_r[`SAC_CFG_CKE] <= 1'b0;
         end
         if (wr_take & is_cmd) begin
            cmd_r <= i_avs_writedata[`SAC_CMD_W-1:0];
         end
         if (wr_take & (i_avs_address == `SAC_REG_WDAT)) begin
            wdat_r <= i_avs_writedata;
         end
         if (cap) begin
            rdat_r <= mem.dq;
         end
         // set beats clear on every sticky flag
         rval_r  <= cap | (rval_r & ~(rd_take
                    & (i_avs_address == `SAC_REG_RDAT)));
         estop_r <= (new_cmd | wr_take) & is_cmd & bad_stop
                    | (estop_r & ~(st_w & i_avs_writedata[`SAC_ST_ESTOP]));
         eap_r   <= (wr_take & is_cmd & bad_ap)
                    | (eap_r & ~(st_w & i_avs_writedata[`SAC_ST_EAP]));
      end
   end

   // ==========================================================
   // command sequencer and pin drivers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= sac_pkg::ST_IDLE;
         mcnt_r  <= '0;
         bus_r   <= {1'b0, `SAC_CMD_NOP};
         ba_r    <= '0;
         addr_r  <= '0;
         dqm_r   <= '0;
         dq_r    <= '0;
         oe_r    <= 1'b0;
         wleft_r <= '0;
         rleft_r <= '0;
      end else begin
         case (state_r)
            sac_pkg::ST_IDLE: begin
               if (new_cmd & need_mk) begin
                  state_r <= sac_pkg::ST_MASK;
                  mcnt_r  <= `SAC_MASK_CYC;
               end else if (fire) begin
                  state_r <= sac_pkg::ST_DRIVE;
               end
            end
            sac_pkg::ST_MASK: begin
               mcnt_r <= mcnt_r - 2'h1;
               if (fire) begin
                  state_r <= sac_pkg::ST_DRIVE;
               end
            end
            sac_pkg::ST_DRIVE: begin
               state_r <= sac_pkg::ST_IDLE;
            end
            default: begin
               state_r <= sac_pkg::ST_IDLE;
            end
         endcase
         // the bus rests on nop, which also covers gate wake-up
         bus_r  <= fire ? {1'b0, sc} : {1'b0, `SAC_CMD_NOP};
         if (fire) begin
            ba_r   <= src[`SAC_CMD_BANK];
            addr_r <= src[`SAC_CMD_ADDR];
         end
         dqm_r <= (new_cmd & need_mk) | (in_mask & ~fire)
                  ? 4'hF : cfg_r[`SAC_CFG_DQM];
         // write data rides the command edge and each one after
         if (f_wr) begin
            dq_r    <= wdat_r;
            oe_r    <= 1'b1;
            wleft_r <= blen - 10'h1;
         end else if (fire) begin
            oe_r    <= 1'b0;
            wleft_r <= '0;
         end else if (wleft_r != 10'h0) begin
            dq_r    <= wdat_r;
            wleft_r <= page ? wleft_r : wleft_r - 10'h1;
         end else begin
            oe_r    <= 1'b0;
         end
         if (f_rd) begin
            rleft_r <= blen + {8'h0, cfg_r[`SAC_CFG_CL]};
         end else if (rleft_r != 10'h0) begin
            rleft_r <= rleft_r - 10'h1;
         end
      end
   end

   assign o_avs_readdata    = rd_r;
   assign o_avs_waitrequest = wait_r;
   assign mem.cs_n       = bus_r[3];
   assign mem.ras_n      = bus_r[2];
   assign mem.cas_n      = bus_r[1];
   assign mem.we_n       = bus_r[0];
   assign mem.cke        = cfg_r[`SAC_CFG_CKE];
   assign mem.ba         = ba_r;
   assign mem.addr       = addr_r;
   assign mem.dqm        = dqm_r;
   assign mem.burst_len  = cfg_r[`SAC_CFG_BL];
   assign mem.interleave = cfg_r[`SAC_CFG_IL];
   assign mem.cas_lat    = cfg_r[`SAC_CFG_CL];
   assign mem.ctl_dq     = dq_r;
   assign mem.ctl_dq_oe  = oe_r;
endmodule : sac_ctrl

// ### bench/sac_bus_props.sv
// property checker on the command bus between controller and device
`include "sac_defs.svh"
module sac_bus_props (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // command bus
   input  wire logic                  cs_n,
   input  wire logic                  ras_n,
   input  wire logic                  cas_n,
   input  wire logic                  we_n,
   input  wire logic [2:0]            burst_len,
   input  wire logic [`SAC_NBYTE-1:0] dqm,
   input  wire logic [`SAC_ADW-1:0]   addr,
   input  wire logic                  ctl_dq_oe,
   input  wire logic [`SAC_NBYTE-1:0] dev_dq_oe
);
   // ==========================================================
   // decode
   wire nop    = ras_n && cas_n && we_n;
   wire acc    = !cs_n && ras_n && !cas_n;
   wire rd     = acc && we_n;
   wire wr     = acc && !we_n;
   wire stp    = !cs_n && ras_n && cas_n && !we_n;
   wire bl4    = burst_len == 3'h2;
   wire dqz    = dqm == 4'h0;
   wire any_rd = |dev_dq_oe;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // properties
   cmd_one_a: assert property (!nop |=> nop)
      else $error("bus command held past one cycle");
   wr_oe_a: assert property (wr |-> ctl_dq_oe)
      else $error("write command without write data");
   wr_burst_a: assert property (wr && bl4 |-> ctl_dq_oe [*4])
      else $error("write burst shorter than four beats");
   wr_end_a: assert property (wr && bl4 ##1 !acc [*4] |-> !ctl_dq_oe)
      else $error("write data driven after burst");
   stop_page_a: assert property (stp |-> burst_len == `SAC_BL_PAGE)
      else $error("burst stop outside full page");
   ap_page_a: assert property (
      acc && addr[`SAC_AP_BIT] |-> burst_len != `SAC_BL_PAGE)
      else $error("auto close with full page");
   dq_excl_a: assert property (ctl_dq_oe |-> dev_dq_oe == 4'h0)
      else $error("both ends drive data pins");
   rd_gap_a: assert property (any_rd |-> !$past(ctl_dq_oe))
      else $error("data pins not free before read data");
   rd_src_a: assert property (
      $rose(any_rd) && $past(dqz, 2) && $past(dqz, 3)
      |-> $past(rd, 2) || $past(rd, 3))
      else $error("read data without read at latency");
   cover property (rd && bl4);
   cover property (wr && $past(any_rd));
   cover property (wr ##2 wr);
endmodule : sac_bus_props

// ### bench/tb_sdram_access_command_core.sv
// self-checking bench for the controller and device pair
`include "sac_defs.svh"
module tb_sdram_access_command_core;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals
   logic                  i_clk;
   logic                  i_rst;
   logic [2:0]            av_addr;
   logic                  av_rd;
   logic                  av_wr;
   logic [31:0]           av_wdata;
   logic [31:0]           av_rdata;
   logic                  av_wait;
   logic [`SAC_NBANK-1:0] bank_open;
   logic                  pdn;
   logic                  sr;
   logic [31:0]           v;
   int                    fails;
   int                    num_checks;
   sac_if mem ();
   sac_ctrl sac_ctrl_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
      .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
      .o_avs_waitrequest(av_wait), .mem(mem.ctl));
   sac_device sac_device_inst (.i_clk(i_clk), .i_rst(i_rst), .mem(mem.dev),
      .o_bank_open(bank_open), .o_read_burst(), .o_write_burst(),
      .o_self_refresh(sr), .o_power_down(pdn));
   sac_bus_props sac_bus_props_inst (.i_clk(i_clk), .i_rst(i_rst),
      .cs_n(mem.cs_n), .ras_n(mem.ras_n), .cas_n(mem.cas_n),
      .we_n(mem.we_n), .burst_len(mem.burst_len), .dqm(mem.dqm),
      .addr(mem.addr), .ctl_dq_oe(mem.ctl_dq_oe),
      .dev_dq_oe(mem.dev_dq_oe));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // ==========================================================
   // bus tasks
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      av_addr  <= a;
      av_wr    <= w;
      av_rd    <= ~w;
      av_wdata <= d;
      @(posedge i_clk);
      while (av_wait !== 1'b0 && n < 40) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 40) fails++;
      v = av_rdata;
   endtask : bus
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      av_wr <= 1'b0;
      @(posedge i_clk);
   endtask : wr
   task automatic rd(input logic [2:0] a);
      bus(1'b0, a, 32'h0);
      av_rd <= 1'b0;
      @(posedge i_clk);
   endtask : rd
   function automatic logic [31:0] cw(input logic [2:0] c,
                                      input logic [11:0] a);
      return {14'h0, a, 3'h0, c};
   endfunction : cw
   task automatic rdc(input logic [11:0] c);
      wr(`SAC_REG_CMD, cw(`SAC_CMD_RD, c));
      repeat (14) @(posedge i_clk);
      rd(`SAC_REG_RDAT);
   endtask : rdc
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // scenarios
   task automatic t_fill;
      wr(`SAC_REG_CFG, 32'h60);
      wr(`SAC_REG_CMD, cw(`SAC_CMD_ACT, 12'h0));
      chk("bank_open", {28'h0, bank_open}, 32'h1);
      for (int c = 0; c < 12; c++) begin
         wr(`SAC_REG_WDAT, 32'hA0000000 + c);
         wr(`SAC_REG_CMD, cw(`SAC_CMD_WR, c[11:0]));
      end
      rdc(12'h9);
      chk("single_rd", v, 32'hA0000009);
      $display("test fill done");
   endtask : t_fill
   task automatic t_order;
      logic [31:0] cfg [6] = '{32'h62, 32'h6A, 32'h63, 32'h6B, 32'h61, 32'h73};
      logic [11:0] st [6] = '{12'h5, 12'h5, 12'h3, 12'h3, 12'h1, 12'h3};
      logic [31:0] ex [6] = '{32'h4, 32'h6, 32'h2, 32'h4, 32'h0, 32'h2};
      for (int i = 0; i < 6; i++) begin
         wr(`SAC_REG_CFG, cfg[i]);
         rdc(st[i]);
         chk("burst_last", v, 32'hA0000000 + ex[i]);
      end
      $display("test order done");
   endtask : t_order
   task automatic t_wrwr;
      logic [11:0] col [4] = '{12'h1, 12'h2, 12'h8, 12'hB};
      logic [31:0] ex [4] = '{32'h55550000, 32'hA0000002, 32'h55550000,
                              32'h55550000};
      wr(`SAC_REG_CFG, 32'h62);
      wr(`SAC_REG_WDAT, 32'h55550000);
      bus(1'b1, `SAC_REG_CMD, cw(`SAC_CMD_WR, 12'h0));
      wr(`SAC_REG_CMD, cw(`SAC_CMD_WR, 12'h8));
      repeat (6) @(posedge i_clk);
      wr(`SAC_REG_CFG, 32'h60);
      for (int i = 0; i < 4; i++) begin
         rdc(col[i]);
         chk("wr_restart", v, ex[i]);
      end
      $display("test write restart done");
   endtask : t_wrwr
   task automatic t_rdwr;
      wr(`SAC_REG_CFG, 32'h63);
      wr(`SAC_REG_WDAT, 32'h77770000);
      bus(1'b1, `SAC_REG_CMD, cw(`SAC_CMD_RD, 12'h0));
      wr(`SAC_REG_CMD, cw(`SAC_CMD_WR, 12'h4));
      repeat (12) @(posedge i_clk);
      wr(`SAC_REG_CFG, 32'h60);
      rdc(12'h4);
      chk("wr_after_rd", v, 32'h77770000);
      $display("test read then write done");
   endtask : t_rdwr
   task automatic t_err;
      wr(`SAC_REG_CFG, 32'h62);
      wr(`SAC_REG_CMD, cw(`SAC_CMD_STOP, 12'h0));
      wr(`SAC_REG_CFG, 32'h67);
      wr(`SAC_REG_CMD, cw(`SAC_CMD_RD, 12'h400));
      rd(`SAC_REG_STAT);
      chk("err_bits", {30'h0, v[2:1]}, 32'h3);
      wr(`SAC_REG_STAT, 32'h6);
      rd(`SAC_REG_STAT);
      chk("err_clear", {30'h0, v[2:1]}, 32'h0);
      rd(3'h7);
      chk("unmapped", v, 32'h0);
      $display("test refusals done");
   endtask : t_err
   task automatic t_pd;
      wr(`SAC_REG_CFG, 32'h20);
      repeat (4) @(posedge i_clk);
      chk("pdown", {31'h0, pdn}, 32'h1);
      wr(`SAC_REG_CFG, 32'h60);
      repeat (3) @(posedge i_clk);
      chk("pdown_exit", {31'h0, pdn}, 32'h0);
      rdc(12'h4);
      chk("after_pd", v, 32'h77770000);
      wr(`SAC_REG_CMD, cw(`SAC_CMD_PRE, 12'h400));
      chk("close_all", {28'h0, bank_open}, 32'h0);
      repeat (2048) wr(`SAC_REG_CMD, 32'h1);
      wr(`SAC_REG_CMD, 32'h9);
      chk("sref", {31'h0, sr}, 32'h1);
      $display("test power down done");
   endtask : t_pd
   // ==========================================================
   // main sequence and watchdog
   initial begin
      i_rst = 1'b1;
      av_addr = 3'h0;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_wdata = 32'h0;
      fails = 0;
      num_checks = 0;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      t_fill();
      t_order();
      t_wrwr();
      t_rdwr();
      t_err();
      t_pd();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      fails++;
      stop_test();
   end
endmodule : tb_sdram_access_command_core
